// *** tli_timer_irq.sv ***
// Five timers with clock-source latencies, flag generation and interrupt arbitration.
// Assumes all pins are synchronous to clk; external clocks are sampled as levels.
`timescale 1ns/1ps

// Operation
// - Synchronous mode register accesses act immediately.
// - Async first timer count reads lag two cycles.
// - Async count write lands after two ticks.
// - External clock timers start two ticks after enable.
// - First timer external enable/disable delayed two ticks.
// - Other timers act on disable with zero latency.
// - Flag rises four cycles after the event.
// - Secondary oscillator clocks first timer when selected.
// - Oscillator runs when fuse low and enabled.
// - Period match sets flag outside gated mode.
// - Gate falling edge sets flag in gated mode.
// - Pair upper timer flag serves 32-bit timer.
// - Flag stays set until software clears it.
// - Zero period generates no interrupt outside gated mode.
// - Flag sets regardless of interrupt enable.
// - Enable bit gates the CPU request.
// - Three-bit priority, zero disables the source.
// - Higher subpriority preempts within a group.
// - Higher group preempts the interrupt in service.
// - Ties go to the lower vector number.
// - Vectors are 4, 8, 12, 16, 20.
// - Deferred requests rise once served flag clears.
module tli_timer_irq
  import tli_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [TLI_NTIM-1:0] extClkIn,
  input wire logic soscClkIn,
  input wire logic [TLI_NTIM-1:0] gateIn,
  input wire logic secondaryOscFuse,
  input wire logic irqAck,
  output logic irqReq,
  output logic [5:0] irqVector,
  output logic [2:0] irqPriority,
  output logic [TLI_NTIM-1:0] timerIrqFlag,
  output logic secondaryOscActive
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [TLI_NTIM-1:0] clkPrev; // Last external clock level.
    logic [TLI_NTIM-1:0] gatePrev; // Last gate level.
    logic [TLI_NTIM-1:0][TLI_EXT_START_TICKS-1:0] onPipe; // Enable seen by the timer clock.
    logic wrPend; // Asynchronous count write in flight.
    logic [1:0] wrTicks; // Timer clocks seen by that write.
    logic [TLI_CW-1:0] wrData; // Value of that write.
    logic [TLI_ASYNC_RD_CYC-1:0][TLI_CW-1:0] cntDly; // Lagged first-timer count.
    logic [TLI_FLAG_DLY-1:0][TLI_NTIM-1:0] evtPipe; // Event synchroniser chain.
    logic [TLI_NTIM-1:0] flag; // Sticky interrupt flags.
    logic [TLI_NTIM-1:0][TLI_CW-1:0] ctrl; // Control registers.
    logic [TLI_NTIM-1:0][TLI_CW-1:0] per; // Period registers.
    logic [TLI_NTIM-1:0] ie; // Interrupt enables.
    logic [TLI_NTIM*TLI_PRI_FIELD-1:0] prio; // Priority fields.
    logic secondary_osc_enable; // Oscillator enable bit.
    logic soscActive; // Oscillator running.
    logic [31:0] rdata; // Read data.
    tli_arb_state_t state; // Arbiter state.
    logic [2:0] activeIdx; // Source in service.
    logic irqReq; // Request to the CPU.
    logic [2:0] irqIdx; // Source requested.
    logic [5:0] irqVec; // Vector requested.
    logic [2:0] irqPri; // Group requested.
    logic [TLI_NTIM-1:0] pendPrev; // Pending set one cycle ago.
  } tli_state_t;

  tli_state_t st_ff; // Registered state.
  tli_state_t nxt_st; // Next state.

  logic [TLI_NTIM-1:0][TLI_CW-1:0] cnt; // Counts from the counters.
  logic [TLI_NTIM-1:0] srcLvl; // Selected clock level.
  logic [TLI_NTIM-1:0] extTick; // Rising edge of that clock.
  logic [TLI_NTIM-1:0] tick; // Count clock per timer.
  logic [TLI_NTIM-1:0] run; // Timer counting.
  logic [TLI_NTIM-1:0] gateFall; // Falling gate edge.
  logic [TLI_NTIM-1:0] inc; // Increment strobes.
  logic [TLI_NTIM-1:0] clr; // Clear strobes.
  logic [TLI_NTIM-1:0] load; // Load strobes.
  logic [TLI_NTIM-1:0][TLI_CW-1:0] loadVal; // Load values.
  logic [TLI_NTIM-1:0] evt; // Timer events.
  logic [TLI_NTIM-1:0] pend; // Enabled pending sources.
  logic [TLI_NTIM-1:0][4:0] keyA; // {group, subpriority} per source.
  logic [2:0] bank; // Register bank.
  logic [1:0] sel; // Register within a bank.
  logic async0; // First timer asynchronous.
  logic incReq; // Increment request scratch.
  logic [31:0] cnt32; // Paired count.
  logic [31:0] per32; // Paired period.
  logic found; // Some source pending.
  logic [2:0] bestIdx; // Winning source.
  logic [4:0] bestKey; // Winning key.
  logic beats; // Winner may request now.

  // ==========================================================
  // Counters
  // ==========================================================
  for (genvar g = 0; g < TLI_NTIM; g++) begin : gCnt
    tli_cnt16 uCnt (
      .clk(clk),
      .resetn(resetn),
      .inc(inc[g]),
      .clr(clr[g]),
      .load(load[g]),
      .loadVal(loadVal[g]),
      .cnt(cnt[g])
    );
  end

  // ==========================================================
  // Next-state logic.
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    bank = regAddr[4:2];
    sel = regAddr[1:0];
    async0 = st_ff.ctrl[0][TLI_CTRL_EXT] & ~st_ff.ctrl[0][TLI_CTRL_SYNC];
    load = '0;
    inc = '0;
    clr = '0;
    evt = '0;
    incReq = 1'b0;
    cnt32 = '0;
    per32 = '0;
    for (int i = 0; i < TLI_NTIM; i++) begin
      loadVal[i] = regWdata[TLI_CW-1:0];
    end
    // The secondary oscillator replaces the first timer's external pin.
    srcLvl = extClkIn;
    if (st_ff.soscActive) begin
      srcLvl[0] = soscClkIn;
    end
    nxt_st.soscActive = ~secondaryOscFuse & st_ff.secondary_osc_enable;
    extTick = srcLvl & ~st_ff.clkPrev;
    nxt_st.clkPrev = srcLvl;
    gateFall = st_ff.gatePrev & ~gateIn;
    nxt_st.gatePrev = gateIn;

    // Asynchronous count write: held until two timer clocks have passed.
    if (regWr && bank == 3'h0 && sel == TLI_SEL_COUNT && async0 && !st_ff.wrPend) begin
      nxt_st.wrPend = 1'b1;
      nxt_st.wrData = regWdata[TLI_CW-1:0];
      nxt_st.wrTicks = 2'h0;
    end
    if (st_ff.wrPend && extTick[0]) begin
      if (st_ff.wrTicks == 2'(TLI_ASYNC_WR_TICKS - 1)) begin
        load[0] = 1'b1;
        loadVal[0] = st_ff.wrData;
        nxt_st.wrPend = 1'b0;
      end else begin
        nxt_st.wrTicks = 2'(st_ff.wrTicks + 2'h1);
      end
    end

    // Per-timer clocking, enable latency, counting and events.
    for (int i = 0; i < TLI_NTIM; i++) begin
      tick[i] = st_ff.ctrl[i][TLI_CTRL_EXT] ? extTick[i] : 1'b1;
      if (extTick[i]) begin
        nxt_st.onPipe[i] = {st_ff.onPipe[i][0], st_ff.ctrl[i][TLI_CTRL_ON]};
      end
      if (i != 0 && !st_ff.ctrl[i][TLI_CTRL_ON]) begin
        nxt_st.onPipe[i] = '0;
      end
      if (!st_ff.ctrl[i][TLI_CTRL_EXT]) begin
        run[i] = st_ff.ctrl[i][TLI_CTRL_ON];
      end else if (i == 0) begin
        run[i] = st_ff.onPipe[i][TLI_EXT_START_TICKS-1];
      end else begin
        run[i] = st_ff.ctrl[i][TLI_CTRL_ON] & st_ff.onPipe[i][TLI_EXT_START_TICKS-1];
      end
      // Synchronous count writes load at once and mask that increment.
      if (regWr && bank == 3'(i) && sel == TLI_SEL_COUNT && !(i == 0 && async0)) begin
        load[i] = 1'b1;
      end
      incReq = run[i] & tick[i] & (~st_ff.ctrl[i][TLI_CTRL_GATE] | gateIn[i]) & ~load[i];
      clr[i] = incReq & (cnt[i] == st_ff.per[i]);
      inc[i] = incReq & (cnt[i] != st_ff.per[i]);
      if (st_ff.ctrl[i][TLI_CTRL_GATE]) begin
        evt[i] = run[i] & gateFall[i];
      end else begin
        evt[i] = inc[i] & (TLI_CW'(cnt[i] + 16'h0001) == st_ff.per[i]) & (st_ff.per[i] != '0);
      end
    end

    // 32-bit pairs: the lower timer drives, the upper timer owns the event.
    for (int p = 1; p < TLI_NTIM; p += 2) begin
      if (st_ff.ctrl[p][TLI_CTRL_PAIR]) begin
        cnt32 = {cnt[p+1], cnt[p]};
        per32 = {st_ff.per[p+1], st_ff.per[p]};
        incReq = run[p] & tick[p] & (~st_ff.ctrl[p][TLI_CTRL_GATE] | gateIn[p]) & ~load[p] & ~load[p+1];
        inc[p] = incReq & (cnt32 != per32);
        clr[p] = incReq & (cnt32 == per32);
        inc[p+1] = inc[p] & (cnt[p] == 16'hFFFF);
        clr[p+1] = clr[p];
        evt[p] = 1'b0;
        if (st_ff.ctrl[p][TLI_CTRL_GATE]) begin
          evt[p+1] = run[p] & gateFall[p];
        end else begin
          evt[p+1] = inc[p] & (32'(cnt32 + 32'h00000001) == per32) & (per32 != '0);
        end
      end
    end

    // Lagged copy of the first count for asynchronous reads.
    nxt_st.cntDly[0] = cnt[0];
    for (int k = 1; k < TLI_ASYNC_RD_CYC; k++) begin
      nxt_st.cntDly[k] = st_ff.cntDly[k-1];
    end

    // Event chain into the flags; software clear loses to a new set.
    nxt_st.evtPipe[0] = evt;
    for (int k = 1; k < TLI_FLAG_DLY; k++) begin
      nxt_st.evtPipe[k] = st_ff.evtPipe[k-1];
    end
    nxt_st.flag = st_ff.flag | st_ff.evtPipe[TLI_FLAG_DLY-1];
    if (regWr && bank == TLI_BANK_GLOBAL && sel == TLI_SEL_FLAG) begin
      nxt_st.flag = (st_ff.flag & ~regWdata[TLI_NTIM-1:0]) | st_ff.evtPipe[TLI_FLAG_DLY-1];
    end

    // Register writes.
    if (regWr) begin
      for (int i = 0; i < TLI_NTIM; i++) begin
        if (bank == 3'(i) && sel == TLI_SEL_CTRL) begin
          nxt_st.ctrl[i] = regWdata[TLI_CW-1:0];
        end
        if (bank == 3'(i) && sel == TLI_SEL_PERIOD) begin
          nxt_st.per[i] = regWdata[TLI_CW-1:0];
        end
      end
      if (bank == TLI_BANK_GLOBAL && sel == TLI_SEL_IE) begin
        nxt_st.ie = regWdata[TLI_NTIM-1:0];
      end
      if (bank == TLI_BANK_GLOBAL && sel == TLI_SEL_PRIO) begin
        nxt_st.prio = regWdata[TLI_NTIM*TLI_PRI_FIELD-1:0];
      end
      if (bank == TLI_BANK_GLOBAL && sel == TLI_SEL_OSC) begin
        nxt_st.secondary_osc_enable = regWdata[TLI_OSC_EN];
      end
    end

    // Read data stand for one cycle only; unmapped reads return zero.
    nxt_st.rdata = '0;
    if (regRd && bank < TLI_BANK_GLOBAL) begin
      case (sel)
        TLI_SEL_CTRL: nxt_st.rdata = {16'h0000, st_ff.ctrl[bank]};
        TLI_SEL_COUNT: begin
          if (bank == 3'h0 && async0) begin
            nxt_st.rdata = {16'h0000, st_ff.cntDly[TLI_ASYNC_RD_CYC-1]};
          end else begin
            nxt_st.rdata = {16'h0000, cnt[bank]};
          end
        end
        TLI_SEL_PERIOD: nxt_st.rdata = {16'h0000, st_ff.per[bank]};
        default: nxt_st.rdata = '0;
      endcase
    end else if (regRd && bank == TLI_BANK_GLOBAL) begin
      case (sel)
        TLI_SEL_FLAG: nxt_st.rdata = {27'h0000000, st_ff.flag};
        TLI_SEL_IE: nxt_st.rdata = {27'h0000000, st_ff.ie};
        TLI_SEL_PRIO: nxt_st.rdata = {7'h00, st_ff.prio};
        default: nxt_st.rdata = {30'h00000000, st_ff.soscActive, st_ff.secondary_osc_enable};
      endcase
    end

    // Arbitration: group, then subpriority, then the lower vector.
    pend = '0;
    found = 1'b0;
    bestIdx = 3'h0;
    bestKey = 5'h00;
    for (int i = 0; i < TLI_NTIM; i++) begin
      keyA[i] = {st_ff.prio[i*TLI_PRI_FIELD+TLI_PRI_LSB +: 3], st_ff.prio[i*TLI_PRI_FIELD+TLI_SUB_LSB +: 2]};
      pend[i] = st_ff.flag[i] & st_ff.ie[i] & (keyA[i][4:2] != 3'h0);
      if (pend[i] && (!found || keyA[i] > bestKey)) begin
        found = 1'b1;
        bestIdx = 3'(i);
        bestKey = keyA[i];
      end
    end
    // An accepted request drops at once and is measured against the source just taken.
    beats = found && ((st_ff.state == TLI_ST_IDLE && !(irqAck && st_ff.irqReq)) ||
      bestKey > keyA[(irqAck && st_ff.irqReq) ? st_ff.irqIdx : st_ff.activeIdx]);
    nxt_st.irqReq = beats;
    nxt_st.irqIdx = bestIdx;
    nxt_st.irqVec = TLI_VECTOR[bestIdx];
    nxt_st.irqPri = bestKey[4:2];
    nxt_st.pendPrev = pend;
    case (st_ff.state)
      TLI_ST_IDLE: begin
        if (irqAck && st_ff.irqReq) begin
          nxt_st.state = TLI_ST_SERVE;
          nxt_st.activeIdx = st_ff.irqIdx;
        end
      end
      TLI_ST_SERVE: begin
        if (irqAck && st_ff.irqReq) begin
          nxt_st.activeIdx = st_ff.irqIdx;
        end else if (!st_ff.flag[st_ff.activeIdx]) begin
          nxt_st.state = TLI_ST_IDLE;
        end
      end
      default: nxt_st.state = TLI_ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register.
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.ctrl <= {TLI_NTIM{TLI_CTRL_RST}};
      st_ff.per <= {TLI_NTIM{TLI_PERIOD_RST}};
      st_ff.state <= TLI_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdata = st_ff.rdata;
  assign irqReq = st_ff.irqReq;
  assign irqVector = st_ff.irqVec;
  assign irqPriority = st_ff.irqPri;
  assign timerIrqFlag = st_ff.flag;
  assign secondaryOscActive = st_ff.soscActive;

  // ==========================================================
  // Assertions.
  // ==========================================================
  property p_flag_lat;
    @(posedge clk) disable iff (!resetn)
      evt[0] && !st_ff.flag[0] && st_ff.evtPipe == '0 |-> ##3 !st_ff.flag[0] ##1 st_ff.flag[0];
  endproperty
  a_flag_lat: assert property (p_flag_lat) else $error("flag late");

  property p_flag_hold;
    @(posedge clk) disable iff (!resetn)
      st_ff.flag[1] && !(regWr && regAddr == {TLI_BANK_GLOBAL, TLI_SEL_FLAG} && regWdata[1]) |=> st_ff.flag[1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_zero_per;
    @(posedge clk) disable iff (!resetn)
      st_ff.per[0] == 16'h0000 && !st_ff.ctrl[0][TLI_CTRL_GATE] |-> !evt[0];
  endproperty
  a_zero_per: assert property (p_zero_per) else $error("event at zero period");

  property p_async_rd;
    @(posedge clk) disable iff (!resetn)
      regRd && regAddr == {3'h0, TLI_SEL_COUNT} && async0 |=> regRdata[15:0] == $past(cnt[0], 3);
  endproperty
  a_async_rd: assert property (p_async_rd) else $error("async read lag");

  property p_sync_rd;
    @(posedge clk) disable iff (!resetn)
      regRd && regAddr == {3'h1, TLI_SEL_COUNT} |=> regRdata[15:0] == $past(cnt[1]);
  endproperty
  a_sync_rd: assert property (p_sync_rd) else $error("sync read lag");

  property p_req_src;
    @(posedge clk) disable iff (!resetn) st_ff.irqReq |-> st_ff.pendPrev[st_ff.irqIdx];
  endproperty
  a_req_src: assert property (p_req_src) else $error("request without enabled flag");

  property p_prio0;
    @(posedge clk) disable iff (!resetn) st_ff.irqReq |-> st_ff.irqPri != 3'h0;
  endproperty
  a_prio0: assert property (p_prio0) else $error("group zero requested");

  property p_tie;
    @(posedge clk) disable iff (!resetn) pend[0] && pend[1] && keyA[0] == keyA[1] |=> st_ff.irqIdx != 3'h1;
  endproperty
  a_tie: assert property (p_tie) else $error("tie went to higher vector");

  property p_vec;
    @(posedge clk) disable iff (!resetn) st_ff.irqReq |-> st_ff.irqVec == 6'({st_ff.irqIdx, 2'b00} + 5'h04);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");

  property p_ext_start;
    @(posedge clk) disable iff (!resetn)
      $rose(run[1]) && st_ff.ctrl[1][TLI_CTRL_EXT] && $past(st_ff.ctrl[1][TLI_CTRL_EXT]) |-> $past(extTick[1]);
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("start not on timer clock");

  property p_release;
    @(posedge clk) disable iff (!resetn)
      st_ff.state == TLI_ST_SERVE && !st_ff.flag[st_ff.activeIdx] && !(irqAck && st_ff.irqReq)
      |=> st_ff.state == TLI_ST_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("service not released");

endmodule : tli_timer_irq

// *** tli_pkg.sv ***
// Shared constants for the timer latency and interrupt block.
// Assumes one 250 MHz clock and a plain register port with 5-bit word addresses.
package tli_pkg;

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int TLI_NTIM = 5; // Number of timers.
  localparam int TLI_CW = 16; // Width of one timer count.

  // ==========================================================
  // Register map: address = {bank, select}
  // ==========================================================
  localparam logic [2:0] TLI_BANK_GLOBAL = 3'h5; // Banks 0 to 4 are the timers.
  localparam logic [1:0] TLI_SEL_CTRL = 2'h0; // Timer control register.
  localparam logic [1:0] TLI_SEL_COUNT = 2'h1; // Timer count register.
  localparam logic [1:0] TLI_SEL_PERIOD = 2'h2; // Timer period register.
  localparam logic [1:0] TLI_SEL_FLAG = 2'h0; // Flags, write one to clear.
  localparam logic [1:0] TLI_SEL_IE = 2'h1; // Interrupt enables.
  localparam logic [1:0] TLI_SEL_PRIO = 2'h2; // Priority and subpriority fields.
  localparam logic [1:0] TLI_SEL_OSC = 2'h3; // Oscillator control register.

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int TLI_CTRL_ON = 15; // Timer enable.
  localparam int TLI_CTRL_GATE = 7; // Gated accumulation mode.
  localparam int TLI_CTRL_PAIR = 3; // 32-bit pairing, lower timer of a pair.
  localparam int TLI_CTRL_SYNC = 2; // External clock synchronised (first timer).
  localparam int TLI_CTRL_EXT = 1; // External clock source.
  localparam int TLI_OSC_EN = 0; // Secondary oscillator enable.
  localparam int TLI_OSC_ACTIVE = 1; // Secondary oscillator running (read only).
  localparam int TLI_PRI_FIELD = 5; // Bits per timer in the priority register.
  localparam int TLI_PRI_LSB = 0; // Priority group lsb within a field.
  localparam int TLI_SUB_LSB = 3; // Subpriority lsb within a field.

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] TLI_CTRL_RST = 16'h0000; // Control reset value.
  localparam logic [15:0] TLI_PERIOD_RST = 16'hFFFF; // Period reset value.
  localparam logic [15:0] TLI_COUNT_RST = 16'h0000; // Count reset value.

  // ==========================================================
  // Timing counts
  // ==========================================================
  localparam int TLI_EXT_START_TICKS = 2; // Timer clocks before enable acts.
  localparam int TLI_ASYNC_WR_TICKS = 2; // Timer clocks before a count write lands.
  localparam int TLI_ASYNC_RD_CYC = 2; // Bus clocks of read lag in asynchronous mode.
  localparam int TLI_FLAG_BUS_CYC = 1; // Bus clock part of the flag latency.
  localparam int TLI_FLAG_SYS_CYC = 2; // System clock part of the flag latency.
  localparam int TLI_FLAG_DLY = TLI_FLAG_BUS_CYC + TLI_FLAG_SYS_CYC; // Total flag latency.

  // ==========================================================
  // Vector numbers, timer 0 in the lowest slot
  // ==========================================================
  localparam logic [4:0][5:0] TLI_VECTOR = {6'h14, 6'h10, 6'h0C, 6'h08, 6'h04};

  // Arbiter states, one-hot.
  typedef enum logic [1:0] {
    TLI_ST_IDLE = 2'b01,
    TLI_ST_SERVE = 2'b10
  } tli_arb_state_t;

endpackage : tli_pkg

// *** tli_cnt16.sv ***
// One 16-bit timer count with clear, load and increment.
// Assumes the caller never asserts clear and increment together.
`timescale 1ns/1ps
module tli_cnt16
  import tli_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic inc,
  input wire logic clr,
  input wire logic load,
  input wire logic [TLI_CW-1:0] loadVal,
  output logic [TLI_CW-1:0] cnt
);

  // State of the counter.
  typedef struct packed {
    logic [TLI_CW-1:0] cnt; // Current count.
  } tli_cnt_state_t;

  tli_cnt_state_t st_ff; // Registered state.
  tli_cnt_state_t nxt_st; // Next state.

  // ==========================================================
  // Next state: clear beats load, load beats increment.
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    if (clr) begin
      nxt_st.cnt = '0;
    end else if (load) begin
      nxt_st.cnt = loadVal;
    end else if (inc) begin
      nxt_st.cnt = TLI_CW'(st_ff.cnt + 16'h0001);
    end
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff.cnt <= TLI_COUNT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cnt = st_ff.cnt;

endmodule : tli_cnt16

// *** tli_cpu_model.sv ***
// Behavioural model of the CPU side of the interrupt link.
// Assumes irqReq and irqVector are driven from clk by the timer block.
`timescale 1ns/1ps
module tli_cpu_model
  import tli_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ackEn,
  input wire logic irqReq,
  input wire logic [5:0] irqVector,
  output logic irqAck,
  output logic [5:0] lastVector
);
  // ==========================================================
  // Acknowledge
  // ==========================================================
  // Accepts a request with a one-cycle pulse and records its vector.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irqAck <= 1'b0;
      lastVector <= 6'h00;
    end else begin
      irqAck <= ackEn & irqReq & ~irqAck;
      if (ackEn && irqReq && !irqAck) begin
        lastVector <= irqVector;
      end
    end
  end
endmodule : tli_cpu_model

// *** test_tli_timer_irq.sv ***
// Self-checking bench for the timer block through its register port.
// Assumes the register map and field positions of the shared package.
`timescale 1ns/1ps
module test_tli_timer_irq;
  import tli_pkg::*;
  logic clk, resetn, regWr, regRd, fuse, ackEn, irqAck, irqReq, oscAct;
  logic [4:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [5:0] irqVector, lastVector;
  logic [2:0] irqPriority;
  logic [4:0] flags;
  logic sosc;
  logic [4:0] extClk, gate;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ==========================================================
  // Clock, design and partner
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  tli_timer_irq u_tli_timer_irq (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extClkIn(extClk), .soscClkIn(sosc),
    .gateIn(gate), .secondaryOscFuse(fuse), .irqAck(irqAck), .irqReq(irqReq), .irqVector(irqVector),
    .irqPriority(irqPriority), .timerIrqFlag(flags), .secondaryOscActive(oscAct));
  tli_cpu_model u_tli_cpu_model (.clk(clk), .resetn(resetn), .ackEn(ackEn), .irqReq(irqReq),
    .irqVector(irqVector), .irqAck(irqAck), .lastVector(lastVector));
  // ==========================================================
  // Tasks
  // ==========================================================
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // One-cycle read strobe; data is sampled in the following cycle.
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rd
  // Pulses {gate, oscillator, external clocks} high for one cycle, n times, low between pulses.
  task automatic pulse(input logic [10:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      {gate, sosc, extClk} <= m;
      @(posedge clk);
      {gate, sosc, extClk} <= 11'h000;
    end
  endtask : pulse
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    {resetn, regWr, regRd, ackEn} = 4'h0;
    {regAddr, regWdata} = '0;
    {gate, sosc, extClk} = '0;
    fuse = 1'b1;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(5'h02, 32'h0000FFFF);
    rd(5'h00, 32'h00000000);
    rd(5'h1C, 32'h00000000);
    // Oscillator stays off while the fuse is high.
    wr(5'h17, 32'h00000001);
    rd(5'h17, 32'h00000001);
    fuse <= 1'b0;
    repeat (2) @(posedge clk);
    rd(5'h17, 32'h00000003);
    // Count writes on a stopped synchronous timer read back at once.
    wr(5'h11, 32'h00001234);
    rd(5'h11, 32'h00001234);
    // Timers 0 and 1 on period five, timer 2 on period zero.
    wr(5'h02, 32'h00000005);
    wr(5'h06, 32'h00000005);
    wr(5'h0A, 32'h00000000);
    wr(5'h00, 32'h00008000);
    wr(5'h04, 32'h00008000);
    wr(5'h08, 32'h00008000);
    repeat (30) @(posedge clk);
    wr(5'h00, 32'h00000000);
    wr(5'h04, 32'h00000000);
    wr(5'h08, 32'h00000000);
    repeat (5) @(posedge clk);
    rd(5'h14, 32'h00000003);
    chk(irqReq, 1'b0);
    // Equal group and subpriority: the lower vector wins.
    wr(5'h16, 32'h000003FF);
    wr(5'h15, 32'h00000003);
    repeat (2) @(posedge clk);
    #1 chk({irqReq, irqPriority, irqVector}, {1'b1, 3'h7, 6'h04});
    // Timer 0 drops to group six; timer 1 now wins.
    wr(5'h16, 32'h000003FE);
    repeat (2) @(posedge clk);
    #1 chk({irqReq, irqPriority, irqVector}, {1'b1, 3'h7, 6'h08});
    // Group zero disables timer 1; timer 0 in group one remains.
    wr(5'h16, 32'h00000001);
    repeat (2) @(posedge clk);
    #1 chk({irqReq, irqPriority, irqVector}, {1'b1, 3'h1, 6'h04});
    // The CPU accepts; the flag stays until software clears it.
    ackEn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(lastVector, 6'h04);
    rd(5'h14, 32'h00000003);
    wr(5'h14, 32'h00000003);
    repeat (2) @(posedge clk);
    #1 chk({irqReq, flags}, 6'h00);
    // Timer 3 on its external clock counts only from the third tick.
    wr(5'h0C, 32'h00008002);
    pulse(11'h008, 2);
    rd(5'h0D, 32'h00000000);
    pulse(11'h008, 1);
    rd(5'h0D, 32'h00000001);
    // Timer 0 asynchronous on the oscillator; a write while one is pending is dropped.
    wr(5'h00, 32'h00000002);
    wr(5'h01, 32'h000000AA);
    pulse(11'h020, 1);
    wr(5'h01, 32'h00000055);
    pulse(11'h020, 1);
    repeat (2) @(posedge clk);
    rd(5'h01, 32'h000000AA);
    // A falling gate edge flags timer 2 in gated mode.
    wr(5'h08, 32'h00008080);
    pulse(11'h100, 1);
    repeat (4) @(posedge clk);
    rd(5'h14, 32'h00000004);
    results();
  end
  // Cuts a hang short well after the tests should have finished.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : test_tli_timer_irq
